// ---- src/gpio_pkg.sv ----
/*
 * package for the four-port gpio block: register indices, reset values,
 * field positions and the packed carriers shared by the port list.
 * assumes an 8-bit register port with one-cycle read latency.
 */
package gpio_pkg;

    // ------------------------------------------------------------
    // register map (word indices)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_PA_DATA = 5'h00;
    localparam logic [4:0] ADDR_PA_DIR = 5'h01;
    localparam logic [4:0] ADDR_PA_PU = 5'h02;
    localparam logic [4:0] ADDR_PA_WU = 5'h03;
    localparam logic [4:0] ADDR_PB_DATA = 5'h04;
    localparam logic [4:0] ADDR_PB_DIR = 5'h05;
    localparam logic [4:0] ADDR_PB_PU = 5'h06;
    localparam logic [4:0] ADDR_PC_DATA = 5'h08;
    localparam logic [4:0] ADDR_PC_DIR = 5'h09;
    localparam logic [4:0] ADDR_PC_PU = 5'h0A;
    localparam logic [4:0] ADDR_PD_DATA = 5'h0C;
    localparam logic [4:0] ADDR_PD_DIR = 5'h0D;
    localparam logic [4:0] ADDR_PD_PU = 5'h0E;
    localparam logic [4:0] ADDR_DRV_LOW = 5'h10;
    localparam logic [4:0] ADDR_DRV_HIGH = 5'h11;
    localparam logic [4:0] ADDR_FUNC_SEL = 5'h12;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DATA8 = 8'hFF;
    localparam logic [7:0] RST_DIR8 = 8'hFF;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    localparam logic [3:0] RST_DATA4 = 4'hF;
    localparam logic [3:0] RST_DIR4 = 4'hF;
    localparam logic [3:0] RST_ZERO4 = 4'h0;
    localparam logic [7:0] DRV_HIGH_MASK = 8'h3F;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ------------------------------------------------------------
    // drive field positions (low bit of each 2-bit field)
    // ------------------------------------------------------------
    localparam int DRV_A_LO = 0;
    localparam int DRV_A_HI = 2;
    localparam int DRV_B_LO = 4;
    localparam int DRV_B_HI = 6;
    localparam int DRV_C_LO = 0;
    localparam int DRV_C_HI = 2;
    localparam int DRV_D_LO = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRIVE_LEVEL0 = 2'b00,
        DRIVE_LEVEL1 = 2'b01,
        DRIVE_LEVEL2 = 2'b10,
        DRIVE_LEVEL3 = 2'b11
    } drive_level_type;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [3:0] fourth_port;
        logic [7:0] third_port;
        logic [7:0] second_port;
        logic [7:0] first_port;
    } pins_type;

    typedef struct packed {
        drive_level_type fourth_lo;
        drive_level_type third_hi;
        drive_level_type third_lo;
        drive_level_type second_hi;
        drive_level_type second_lo;
        drive_level_type first_hi;
        drive_level_type first_lo;
    } drive_type;

    typedef enum logic [1:0] {
        RESET_NONE = 2'b00,
        RESET_FULL = 2'b01,
        RESET_SLEEP_WDT = 2'b10
    } reset_kind_type;

endpackage : gpio_pkg

// ---- src/gpio_ports_with_wakeup.sv ----
/*
 * gpio block with three 8-bit ports, one 4-bit port, pull-high enables,
 * falling-edge wake-up on the first port and source-current levels.
 * assumes a single 20 MHz clock, synchronous reset, and pads that build
 * the pin wire from out, oe_n and pull-high.
 */
//
// Contract
// - output latch holds written value until software writes it again
// - pin inputs not latched; read samples live synchronised pin level
// - direction bit 1 input, 0 push-pull output from latch
// - input pin read returns pin level
// - output pin read returns latch contents
// - pull-high bit 1 enables, effective only while pin is input
// - pull-high only when pin function is digital input or open-drain
// - enabled first-port pin falling edge wakes device from sleep
// - eight first-port wake enable bits, 1 enables
// - wake enable acts only for gpio function in power-down
// - drive field 00 level 0 up to 11 level 3
// - low drive register: first port bits 3..0, second port 7..4
// - high drive register: fourth port bits 5..4, bits 7..6 read zero
// - fourth port implements only four data, direction, pull-high bits
// - fourth port resets data/dir 1111, pull 0000; sleep wdt keeps
// - high drive register: third port bits 3..2 and 1..0
module gpio_ports_with_wakeup (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // reset cause and power state
    input wire gpio_pkg::reset_kind_type reset_kind_in,
    input wire logic power_down_in,
    // register port
    input wire gpio_pkg::reg_req_type req_in,
    output gpio_pkg::pins_type read_data_out,
    // pins
    input wire gpio_pkg::pins_type pin_in,
    output gpio_pkg::pins_type pin_out,
    output gpio_pkg::pins_type pin_oe_n_out,
    output gpio_pkg::pins_type pullhigh_out,
    output gpio_pkg::drive_type drive_out,
    // wake-up
    output logic wake_out
);
    import gpio_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    pins_type port_data;
    pins_type port_dir;
    pins_type port_pu;
    pins_type func_gpio;
    logic [7:0] wake_enable;
    logic [7:0] drv_low;
    logic [7:0] drv_high;
    pins_type pin_meta;
    pins_type pin_sync;
    logic [7:0] first_prev;
    logic [7:0] rdata;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input reg_req_type r, input logic [4:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                             input logic [7:0] pin);
        return (dir & pin) | (~dir & lat);
    endfunction

    wire full_reset = srst_in && (reset_kind_in != RESET_SLEEP_WDT);
    wire [7:0] view_a = port_view(port_dir.first_port, port_data.first_port, pin_sync.first_port);
    wire [7:0] view_b = port_view(port_dir.second_port, port_data.second_port, pin_sync.second_port);
    wire [7:0] view_c = port_view(port_dir.third_port, port_data.third_port, pin_sync.third_port);
    wire [7:0] view_d = port_view({4'h0, port_dir.fourth_port}, {4'h0, port_data.fourth_port},
                                  {4'h0, pin_sync.fourth_port});
    wire [7:0] fall_a = first_prev & ~pin_sync.first_port;
    wire [7:0] wake_hit = fall_a & wake_enable & func_gpio.first_port;
    wire next_wake = power_down_in && (|wake_hit);
    wire pins_type next_pull = port_dir & port_pu & func_gpio;

    always_comb begin
        rdata = READ_IDLE;
        case (req_in.addr)
            ADDR_PA_DATA: rdata = view_a;
            ADDR_PA_DIR: rdata = port_dir.first_port;
            ADDR_PA_PU: rdata = port_pu.first_port;
            ADDR_PA_WU: rdata = wake_enable;
            ADDR_PB_DATA: rdata = view_b;
            ADDR_PB_DIR: rdata = port_dir.second_port;
            ADDR_PB_PU: rdata = port_pu.second_port;
            ADDR_PC_DATA: rdata = view_c;
            ADDR_PC_DIR: rdata = port_dir.third_port;
            ADDR_PC_PU: rdata = port_pu.third_port;
            ADDR_PD_DATA: rdata = view_d;
            ADDR_PD_DIR: rdata = {4'h0, port_dir.fourth_port};
            ADDR_PD_PU: rdata = {4'h0, port_pu.fourth_port};
            ADDR_DRV_LOW: rdata = drv_low;
            ADDR_DRV_HIGH: rdata = drv_high & DRV_HIGH_MASK;
            ADDR_FUNC_SEL: rdata = func_gpio.first_port;
            default: rdata = READ_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
        first_prev <= pin_sync.first_port;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // sleep-time watchdog keeps state
    always_ff @(posedge clock_in) begin
        if (full_reset) begin
            port_data <= {RST_DATA4, RST_DATA8, RST_DATA8, RST_DATA8};
            port_dir <= {RST_DIR4, RST_DIR8, RST_DIR8, RST_DIR8};
            port_pu <= {RST_ZERO4, RST_ZERO8, RST_ZERO8, RST_ZERO8};
            func_gpio <= {RST_DATA4, RST_DATA8, RST_DATA8, RST_DATA8};
            wake_enable <= RST_ZERO8;
            drv_low <= RST_ZERO8;
            drv_high <= RST_ZERO8;
        end else if (!srst_in) begin
            if (hit(req_in, ADDR_PA_DATA)) begin
                port_data.first_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PB_DATA)) begin
                port_data.second_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PC_DATA)) begin
                port_data.third_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PD_DATA)) begin
                port_data.fourth_port <= req_in.wdata[3:0];
            end
            if (hit(req_in, ADDR_PA_DIR)) begin
                port_dir.first_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PB_DIR)) begin
                port_dir.second_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PC_DIR)) begin
                port_dir.third_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PD_DIR)) begin
                port_dir.fourth_port <= req_in.wdata[3:0];
            end
            if (hit(req_in, ADDR_PA_PU)) begin
                port_pu.first_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PB_PU)) begin
                port_pu.second_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PC_PU)) begin
                port_pu.third_port <= req_in.wdata;
            end
            if (hit(req_in, ADDR_PD_PU)) begin
                port_pu.fourth_port <= req_in.wdata[3:0];
            end
            if (hit(req_in, ADDR_PA_WU)) begin
                wake_enable <= req_in.wdata;
            end
            if (hit(req_in, ADDR_DRV_LOW)) begin
                drv_low <= req_in.wdata;
            end
            if (hit(req_in, ADDR_DRV_HIGH)) begin
                drv_high <= req_in.wdata & DRV_HIGH_MASK;
            end
            if (hit(req_in, ADDR_FUNC_SEL)) begin
                func_gpio.first_port <= req_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            read_data_out <= '0;
            pin_out <= '0;
            pin_oe_n_out <= '1;
            pullhigh_out <= '0;
            drive_out <= '0;
            wake_out <= 1'b0;
        end else begin
            read_data_out <= {20'h00000, req_in.rd ? rdata : READ_IDLE};
            pin_out <= port_data;
            pin_oe_n_out <= port_dir;
            pullhigh_out <= next_pull;
            drive_out.first_lo <= drive_level_type'(drv_low[DRV_A_LO +: 2]);
            drive_out.first_hi <= drive_level_type'(drv_low[DRV_A_HI +: 2]);
            drive_out.second_lo <= drive_level_type'(drv_low[DRV_B_LO +: 2]);
            drive_out.second_hi <= drive_level_type'(drv_low[DRV_B_HI +: 2]);
            drive_out.third_lo <= drive_level_type'(drv_high[DRV_C_LO +: 2]);
            drive_out.third_hi <= drive_level_type'(drv_high[DRV_C_HI +: 2]);
            drive_out.fourth_lo <= drive_level_type'(drv_high[DRV_D_LO +: 2]);
            wake_out <= next_wake;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_latch_hold;
        @(posedge clock_in) disable iff (srst_in)
        !hit(req_in, ADDR_PA_DATA) |=> port_data.first_port == $past(port_data.first_port);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

    property p_read_view;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_PB_DATA |=> read_data_out[7:0] == $past(view_b);
    endproperty
    a_read_view: assert property (p_read_view) else $error("port read wrong");

    property p_oe_dir;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> pin_oe_n_out == $past(port_dir);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("enable not from direction");

    property p_pull_off_output;
        @(posedge clock_in) disable iff (srst_in)
        port_dir.first_port[0] == 1'b0 |=> pullhigh_out.first_port[0] == 1'b0;
    endproperty
    a_pull_off_output: assert property (p_pull_off_output) else $error("pull on output pin");

    property p_wake_needs_pd;
        @(posedge clock_in) disable iff (srst_in)
        wake_out |-> $past(power_down_in) && $past(|(wake_enable & func_gpio.first_port));
    endproperty
    a_wake_needs_pd: assert property (p_wake_needs_pd) else $error("wake without power-down");

    property p_drv_high_zero;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_DRV_HIGH |=> read_data_out[7:6] == 2'b00;
    endproperty
    a_drv_high_zero: assert property (p_drv_high_zero) else $error("drive high top bits set");

    property p_fourth_narrow;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_PD_DIR |=> read_data_out[7:4] == 4'h0;
    endproperty
    a_fourth_narrow: assert property (p_fourth_narrow) else $error("fourth port upper bits set");

    property p_reset_vals;
        @(posedge clock_in)
        full_reset |=> port_dir == '1 && port_pu == '0 && wake_enable == 8'h00 && drv_low == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    // ------------------------------------------------------------
    // checks: latch, reads and direction
    // ------------------------------------------------------------
    property p_pin_out_latch;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> pin_out == $past(port_data);
    endproperty
    a_pin_out_latch: assert property (p_pin_out_latch) else $error("pin out not from latch");

    property p_read_input;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_PC_DATA && port_dir.third_port == 8'hFF
        |=> read_data_out[7:0] == $past(pin_sync.third_port);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read not pin level");

    property p_read_latch;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_PA_DATA && port_dir.first_port == 8'h00
        |=> read_data_out[7:0] == $past(port_data.first_port);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read not latch");

    property p_read_upper;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> read_data_out[27:8] == 20'h00000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("read upper bits set");

    property p_read_idle;
        @(posedge clock_in) disable iff (srst_in)
        !req_in.rd |=> read_data_out[7:0] == READ_IDLE;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without strobe");

    property p_fourth_data;
        @(posedge clock_in) disable iff (srst_in)
        req_in.rd && req_in.addr == ADDR_PD_DATA |=> read_data_out[7:4] == 4'h0;
    endproperty
    a_fourth_data: assert property (p_fourth_data) else $error("fourth data upper bits set");

    property p_write_dir;
        @(posedge clock_in) disable iff (srst_in)
        hit(req_in, ADDR_PA_DIR) |=> port_dir.first_port == $past(req_in.wdata);
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("direction write lost");

    // ------------------------------------------------------------
    // checks: pull-high, drive and wake
    // ------------------------------------------------------------
    property p_pull_input;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (pullhigh_out & ~$past(port_dir)) == '0;
    endproperty
    a_pull_input: assert property (p_pull_input) else $error("pull on output pin");

    property p_pull_func;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (pullhigh_out.first_port & ~$past(func_gpio.first_port)) == 8'h00;
    endproperty
    a_pull_func: assert property (p_pull_func) else $error("pull on non-gpio pin");

    property p_pull_enable;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (pullhigh_out & ~$past(port_pu)) == '0;
    endproperty
    a_pull_enable: assert property (p_pull_enable) else $error("pull without enable");

    property p_drive_low;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> drive_out[7:0] == $past(drv_low);
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("low drive fields misplaced");

    property p_drive_high;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |=> drive_out[13:8] == $past(drv_high[5:0]);
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("high drive fields misplaced");

    property p_drv_high_reg;
        @(posedge clock_in) disable iff (srst_in)
        1'b1 |-> drv_high[7:6] == 2'b00;
    endproperty
    a_drv_high_reg: assert property (p_drv_high_reg) else $error("drive high top bits held");

    property p_wake_fires;
        @(posedge clock_in) disable iff (srst_in)
        power_down_in && |(wake_enable & func_gpio.first_port & first_prev & ~pin_sync.first_port) |=> wake_out;
    endproperty
    a_wake_fires: assert property (p_wake_fires) else $error("enabled falling edge missed");

    property p_wake_enable;
        @(posedge clock_in) disable iff (srst_in)
        wake_out |-> $past(|(wake_enable & first_prev & ~pin_sync.first_port));
    endproperty
    a_wake_enable: assert property (p_wake_enable) else $error("wake from disabled pin");

    // ------------------------------------------------------------
    // checks: reset kinds
    // ------------------------------------------------------------
    property p_sleep_keep;
        @(posedge clock_in)
        srst_in && reset_kind_in == RESET_SLEEP_WDT |=> port_dir == $past(port_dir) && port_pu == $past(port_pu);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("sleep watchdog cleared state");

    property p_full_reset_fourth;
        @(posedge clock_in)
        full_reset |=> port_data.fourth_port == RST_DATA4 && port_dir.fourth_port == RST_DIR4
            && port_pu.fourth_port == RST_ZERO4;
    endproperty
    a_full_reset_fourth: assert property (p_full_reset_fourth) else $error("fourth port reset wrong");

endmodule // gpio_ports_with_wakeup

// ---- tb/pin_model.sv ----
/*
 * board-side model of the pins: external drivers, pull-high and floating lines.
 * assumes the device outputs are registered on clock_in.
 */
module pin_model (
    // clock
    input wire logic clock_in,
    // device side
    input wire gpio_pkg::pins_type drv_in,
    input wire gpio_pkg::pins_type oe_n_in,
    input wire gpio_pkg::pins_type pull_in,
    // board side
    input wire gpio_pkg::pins_type ext_en_in,
    input wire gpio_pkg::pins_type ext_val_in,
    output gpio_pkg::pins_type level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_pkg::*;
    logic [27:0] last_level = 28'h0000000;

    // device wins, then board driver, then pull-high, else a floating line flips
    always_comb begin
        for (int i = 0; i < 28; i++) begin
            if (!oe_n_in[i]) level_out[i] = drv_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pull_in[i]) level_out[i] = 1'b1;
            else level_out[i] = ~last_level[i];
        end
    end

    always_ff @(posedge clock_in) last_level <= level_out;
endmodule // pin_model

// ---- tb/testbench.sv ----
/*
 * self-checking bench for the four-port gpio block with the board model.
 * assumes the register port answers reads one cycle after the strobe.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_pkg::*;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic power_down_in = 1'b0;
    reset_kind_type reset_kind_in = RESET_FULL;
    reg_req_type req_in = '0;
    pins_type ext_val = '1, ext_en = '1, pin_level, rd_data, pin_out, oe_n, pull;
    drive_type drive_out;
    logic wake_out, rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v, w;
    logic [31:0] pv, ev;
    int bad_count = 0, total_checks = 0, wakes = 0;
    logic [4:0] addr_tab[11] = '{ADDR_PA_DIR, ADDR_PA_PU, ADDR_PA_WU, ADDR_PB_DIR, ADDR_PB_PU, ADDR_PC_DIR,
        ADDR_PC_PU, ADDR_PD_DIR, ADDR_PD_PU, ADDR_DRV_LOW, ADDR_DRV_HIGH};
    logic [7:0] mask_tab[11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h3F};
    logic [7:0] rst_tab[11] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
    logic [4:0] data_tab[4] = '{ADDR_PA_DATA, ADDR_PB_DATA, ADDR_PC_DATA, ADDR_PD_DATA};
    logic [4:0] dir_tab[4] = '{ADDR_PA_DIR, ADDR_PB_DIR, ADDR_PC_DIR, ADDR_PD_DIR};
    logic [4:0] pu_tab[4] = '{ADDR_PA_PU, ADDR_PB_PU, ADDR_PC_PU, ADDR_PD_PU};

    always #25 clock_in = ~clock_in;

    gpio_ports_with_wakeup dut (.clock_in(clock_in), .srst_in(srst_in), .reset_kind_in(reset_kind_in),
        .power_down_in(power_down_in), .req_in(req_in), .read_data_out(rd_data), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe_n_out(oe_n), .pullhigh_out(pull), .drive_out(drive_out), .wake_out(wake_out));
    pin_model board (.clock_in(clock_in), .drv_in(pin_out), .oe_n_in(oe_n), .pull_in(pull),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_level));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check_value(string what, logic [27:0] exp, logic [27:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(logic [4:0] a, logic [7:0] d, logic wr, logic rd);
        req_in <= '{addr: a, wdata: d, wr: wr, rd: rd};
        @(posedge clock_in);
    endtask

    task automatic rd(logic [4:0] a, logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic idle(int n);
        req_in <= '0;
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic wake_try(int b, logic exp);
        ext_val[b] <= 1'b0;
        wakes = 0;
        idle(8);
        check_value("wake pulses", {27'h0, exp}, 28'(wakes));
        ext_val[b] <= 1'b1;
        idle(4);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(posedge clock_in) begin
        if (rd_seen) check_value("read data", {20'h0, exp_q.pop_front()}, rd_data);
        rd_seen <= req_in.rd & ~srst_in;
        if (wake_out === 1'b1) wakes <= wakes + 1;
    end

    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    initial begin
        void'($urandom(28104));
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        idle(1);
        check_value("oe_n", 28'hFFFFFFF, oe_n);
        check_value("pullhigh", 28'h0, pull);
        for (int i = 0; i < 11; i++) begin
            v = 8'($urandom);
            rd(addr_tab[i], rst_tab[i]);
            bus(addr_tab[i], v, 1'b1, 1'b0);
            rd(addr_tab[i], v & mask_tab[i]);
        end
        bus(5'h1F, 8'hA5, 1'b1, 1'b0);
        rd(5'h1F, 8'h00);
        idle(2);
        $display("test registers done");
        pv = $urandom;
        for (int j = 0; j < 4; j++) begin
            bus(dir_tab[j], 8'h00, 1'b1, 1'b0);
            bus(pu_tab[j], 8'hFF, 1'b1, 1'b0);
            bus(data_tab[j], pv[8*j +: 8], 1'b1, 1'b0);
        end
        ext_val <= ~pv[27:0];
        idle(4);
        check_value("pin_out", pv[27:0], pin_out);
        check_value("oe_n", 28'h0, oe_n);
        check_value("pullhigh", 28'h0, pull);
        for (int j = 0; j < 4; j++) rd(data_tab[j], pv[8*j +: 8] & (j == 3 ? 8'h0F : 8'hFF));
        idle(2);
        $display("test output latch done");
        ev = $urandom & 32'h0FFFFFFF;
        for (int j = 0; j < 4; j++) bus(dir_tab[j], 8'hFF, 1'b1, 1'b0);
        ext_val <= ev[27:0];
        idle(4);
        check_value("pullhigh", 28'hFFFFFFF, pull);
        for (int j = 0; j < 4; j++) rd(data_tab[j], ev[8*j +: 8]);
        ext_val <= ~ev[27:0];
        idle(4);
        rd(ADDR_PA_DATA, ~ev[7:0]);
        bus(ADDR_FUNC_SEL, 8'h00, 1'b1, 1'b0);
        idle(3);
        check_value("pullhigh", 28'hFFFFF00, pull);
        bus(ADDR_FUNC_SEL, 8'hFF, 1'b1, 1'b0);
        idle(2);
        $display("test inputs and pull-high done");
        for (int k = 0; k < 5; k++) begin
            v = (k == 0) ? 8'hE4 : 8'($urandom);
            w = (k == 0) ? 8'hDB : 8'($urandom);
            bus(ADDR_DRV_LOW, v, 1'b1, 1'b0);
            bus(ADDR_DRV_HIGH, w, 1'b1, 1'b0);
            idle(3);
            check_value("drive", {14'h0, w[5:0], v}, {14'h0, drive_out});
        end
        $display("test drive levels done");
        ext_val <= '1;
        power_down_in <= 1'b1;
        idle(4);
        for (int b = 0; b < 8; b++) begin
            bus(ADDR_PA_WU, 8'h01 << b, 1'b1, 1'b0);
            idle(2);
            wake_try(b, 1'b1);
            wake_try((b + 1) % 8, 1'b0);
        end
        power_down_in <= 1'b0;
        wake_try(7, 1'b0);
        power_down_in <= 1'b1;
        bus(ADDR_FUNC_SEL, 8'h7F, 1'b1, 1'b0);
        wake_try(7, 1'b0);
        $display("test wake-up done");
        bus(ADDR_PD_DIR, 8'h00, 1'b1, 1'b0);
        bus(ADDR_PD_PU, 8'h0F, 1'b1, 1'b0);
        bus(ADDR_PA_WU, 8'h55, 1'b1, 1'b0);
        reset_kind_in <= RESET_SLEEP_WDT;
        srst_in <= 1'b1;
        idle(3);
        srst_in <= 1'b0;
        idle(1);
        rd(ADDR_PD_DIR, 8'h00);
        rd(ADDR_PD_PU, 8'h0F);
        rd(ADDR_PA_WU, 8'h55);
        rd(ADDR_FUNC_SEL, 8'h7F);
        reset_kind_in <= RESET_FULL;
        srst_in <= 1'b1;
        idle(3);
        srst_in <= 1'b0;
        idle(1);
        rd(ADDR_PD_DIR, 8'h0F);
        rd(ADDR_PD_PU, 8'h00);
        rd(ADDR_PA_WU, 8'h00);
        bus(ADDR_PD_DIR, 8'h00, 1'b1, 1'b0);
        rd(ADDR_PD_DATA, 8'h0F);
        idle(2);
        $display("test resets done");
        final_report();
    end
endmodule // testbench
